// ===== clk_board_model.sv
// board side model: strap levels and the external clock on the bidirectional pin
module clk_board_model (
  // clock and chosen strap code
  input wire logic pclk,
  input wire logic [2:0] mode_sel,
  // pin wires
  input wire logic bidir_clk_o,
  input wire logic bidir_clk_oe,
  output logic [2:0] mode_strap_pins,
  output logic bidir_clk_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ext_clk = 1'b0;
  logic idle_pat = 1'b0;
  // straps are plain levels, highest pin as msb
  assign mode_strap_pins = mode_sel;
  always #37 ext_clk = ~ext_clk;
  // undriven pin moves every cycle so a stale level never looks valid
  always @(posedge pclk) idle_pat <= ~idle_pat;
  // wire level from both parties' enables; board drives only in modes 6 and 7
  assign bidir_clk_i = bidir_clk_oe ? bidir_clk_o :
                       (mode_sel[2:1] == 2'h3) ? ext_clk : idle_pat;
endmodule

// ===== clk_mode_decode.sv
// fixed per-mode decode of clock source, pll factors and pin phase relation
module clk_mode_decode
  import clk_mode_pkg::*;
(
  // selected mode and external bus divider
  input wire logic [2:0] mode,
  input wire logic [1:0] extbus_div,
  // decoded configuration
  output logic [1:0] src_sel,
  output logic [2:0] pll1_factor,
  output logic [2:0] pll2_factor,
  output logic [1:0] phase_rel,
  output logic [15:0] reset_value
);
  // per mode table
  always_comb begin
    src_sel = SRC_OSC;
    pll1_factor = PLL_OFF;
    pll2_factor = PLL_OFF;
    phase_rel = PH_NONE;
    reset_value = RST_MODE7;
    case (mode)
      3'h0, 3'h1: begin
        pll1_factor = PLL_X2;
        pll2_factor = PLL_X2;
        reset_value = (mode == 3'h0) ? RST_MODE0 : RST_MODE1;
        case (extbus_div)
          DIV_X1: phase_rel = PH_PIN_EDGE_ON_RISE;
          DIV_HALF: phase_rel = PH_IN_PHASE;
          DIV_QUARTER: phase_rel = PH_PIN_RISE_ON_EDGE;
          default: phase_rel = PH_NONE;
        endcase
      end
      3'h2, 3'h3: begin
        pll1_factor = PLL_X1;
        pll2_factor = PLL_X4;
        reset_value = (mode == 3'h2) ? RST_MODE2 : RST_MODE3;
        case (extbus_div)
          DIV_X1: phase_rel = PH_IN_PHASE;
          DIV_HALF, DIV_QUARTER: phase_rel = PH_PIN_RISE_ON_EDGE;
          default: phase_rel = PH_NONE;
        endcase
      end
      3'h4, 3'h5: begin
        pll2_factor = PLL_X4;
        reset_value = (mode == 3'h4) ? RST_MODE4 : RST_MODE5;
        phase_rel = PH_NONE;
      end
      3'h6: begin
        src_sel = SRC_BIDIR;
        pll1_factor = PLL_X2;
        reset_value = RST_MODE6;
        case (extbus_div)
          DIV_X1: phase_rel = PH_PIN_EDGE_ON_RISE;
          DIV_HALF: phase_rel = PH_IN_PHASE;
          DIV_QUARTER: phase_rel = PH_PIN_RISE_ON_EDGE;
          default: phase_rel = PH_NONE;
        endcase
      end
      default: begin
        src_sel = SRC_BIDIR;
        pll1_factor = PLL_X1;
        reset_value = RST_MODE7;
        case (extbus_div)
          DIV_X1: phase_rel = PH_IN_PHASE;
          DIV_HALF, DIV_QUARTER: phase_rel = PH_PIN_RISE_ON_EDGE;
          default: phase_rel = PH_NONE;
        endcase
      end
    endcase
  end
endmodule

// ===== clk_mode_pkg.sv
// constants shared by the clock mode selection block
package clk_mode_pkg;
  // register map (byte address)
  localparam logic [31:0] FREQ_CTRL_ADDR = 32'hffff1028;
  // field positions
  localparam int BIDIR_OE_BIT = 15;
  localparam int AUX_OE_BIT = 14;
  localparam int AUX_DIV_LSB = 6;
  localparam int CORE_DIV_LSB = 4;
  localparam int PERIPH_DIV_LSB = 2;
  localparam int EXTBUS_DIV_LSB = 0;
  // writable bits of the register; 13:8 read as zero
  localparam logic [15:0] FREQ_CTRL_WMASK = 16'hc0ff;
  // reset value per clock mode
  localparam logic [15:0] RST_MODE0 = 16'hc0aa;
  localparam logic [15:0] RST_MODE1 = 16'hc045;
  localparam logic [15:0] RST_MODE2 = 16'hc0aa;
  localparam logic [15:0] RST_MODE3 = 16'hc044;
  localparam logic [15:0] RST_MODE4 = 16'h40aa;
  localparam logic [15:0] RST_MODE5 = 16'h4045;
  localparam logic [15:0] RST_MODE6 = 16'h4045;
  localparam logic [15:0] RST_MODE7 = 16'h4000;
  // divider codes
  localparam logic [1:0] DIV_X1 = 2'h0;
  localparam logic [1:0] DIV_HALF = 2'h1;
  localparam logic [1:0] DIV_QUARTER = 2'h2;
  localparam logic [1:0] DIV_BAD = 2'h3;
  // pll factors
  localparam logic [2:0] PLL_X1 = 3'h1;
  localparam logic [2:0] PLL_X2 = 3'h2;
  localparam logic [2:0] PLL_X4 = 3'h4;
  localparam logic [2:0] PLL_OFF = 3'h0;
  // source and phase codes
  localparam logic [1:0] SRC_OSC = 2'h0;
  localparam logic [1:0] SRC_BIDIR = 2'h1;
  localparam logic [1:0] PH_NONE = 2'h0;
  localparam logic [1:0] PH_IN_PHASE = 2'h1;
  localparam logic [1:0] PH_PIN_EDGE_ON_RISE = 2'h2;
  localparam logic [1:0] PH_PIN_RISE_ON_EDGE = 2'h3;
  // cycles after reset release before the strap is caught and the register loaded
  localparam int STRAP_SYNC_CYCLES = 2;
endpackage

// ===== clock_mode_pll_select.sv
// clock mode selection, frequency control register and clock pin control
// Contract
// - three strap pins select one of eight clock modes
// - register at fixed address, byte/half/word access, mode-dependent reset
// - modes 0,1 oscillator source, both plls at x2
// - modes 0,1 pin phase follows extbus ratio x2/x1/half
// - modes 2,3 oscillator source, pll1 x1, pll2 x4
// - modes 2,3 in phase at x1, rise-on-edge otherwise
// - aux pin carries clock at register-selected frequency
// - aux pin high impedance when its enable is clear
// - modes 4,5 oscillator source, only pll2 at x4
// - modes 4,5 bidir pin hi-z by default, pll1 off
// - modes 4,5 software may enable bidir pin output
// - mode 6 pin source, only pll1 at x2
// - mode 6 phase follows extbus ratio x2/x1/half
// - mode 7 pin source, only pll1 at x1
// - mode 7 in phase at x1, rise-on-edge at half, quarter
// - bidir enable resets by mode; illegal writes kept out
// - two-bit divider fields encode x1, half, quarter; 11 forbidden
// - aux enable bit 14, reset one, zero means hi-z
module clock_mode_pll_select
  import clk_mode_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap pins
  input wire logic [2:0] mode_strap_pins,
  // aux clock pin
  output logic aux_clk_o,
  output logic aux_clk_oe,
  // bidirectional clock pin
  input wire logic bidir_clk_i,
  output logic bidir_clk_o,
  output logic bidir_clk_oe,
  // decoded configuration to the clock tree
  output logic [2:0] mode_o,
  output logic [1:0] src_sel_o,
  output logic [2:0] pll1_factor_o,
  output logic [2:0] pll2_factor_o,
  output logic [1:0] phase_rel_o,
  output logic [1:0] core_div_o,
  output logic [1:0] periph_div_o,
  output logic [1:0] extbus_div_o
);
  // strap synchroniser and load state
  logic [2:0] strap_meta_ff;
  logic [2:0] strap_sync_ff;
  logic [2:0] mode_ff;
  logic [1:0] load_cnt_ff;
  logic loaded_ff;
  logic [15:0] freq_ctrl_reg_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [1:0] aux_cnt_ff;
  logic aux_clk_ff;
  logic aux_oe_ff;
  logic bidir_o_ff;
  logic bidir_oe_ff;
  logic [1:0] src_ff;
  logic [2:0] pll1_ff;
  logic [2:0] pll2_ff;
  logic [1:0] phase_ff;
  // bidir pin input is synchronised, only to be observed in pin-source modes
  logic bidir_meta_ff;
  logic bidir_sync_ff;

  // decode wires
  logic [1:0] dec_src;
  logic [2:0] dec_pll1;
  logic [2:0] dec_pll2;
  logic [1:0] dec_phase;
  logic [15:0] dec_reset;
  wire [15:0] cur_reg = freq_ctrl_reg_ff;

  clk_mode_decode u_decode (
    .mode(mode_ff),
    .extbus_div(cur_reg[EXTBUS_DIV_LSB +: 2]),
    .src_sel(dec_src),
    .pll1_factor(dec_pll1),
    .pll2_factor(dec_pll2),
    .phase_rel(dec_phase),
    .reset_value(dec_reset)
  );

  // apb decode; one wait state, answer in the second access cycle
  wire addr_hit = (paddr[31:2] == FREQ_CTRL_ADDR[31:2]);
  wire acc_phase = psel && penable && !pready_ff;
  wire wr_take = psel && penable && pready_ff && pwrite && addr_hit && loaded_ff;
  wire bad_addr = !addr_hit;
  // the register sits in the low halfword of the word at offset 0x28, byte offset 0 within it
  wire [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] wmask = lane_mask & FREQ_CTRL_WMASK;
  wire [15:0] merged = (cur_reg & ~wmask) | (pwdata[15:0] & wmask);

  // forbidden divider code keeps old field
  // fields sit back to back from the extbus field upward, one slice each
  logic [7:0] new_divs;
  for (genvar f = 0; f < 4; f++) begin : g_div
    wire [1:0] wr_code = merged[EXTBUS_DIV_LSB + 2*f +: 2];
    assign new_divs[2*f +: 2] = (wr_code == DIV_BAD) ?
      cur_reg[EXTBUS_DIV_LSB + 2*f +: 2] : wr_code;
  end

  // enable forced on in modes 0-3, off in 6,7
  // modes 4,5 take the written enable
  wire bidir_oe_new = (mode_ff <= 3'h3) ? 1'b1 :
    (mode_ff >= 3'h6) ? 1'b0 : merged[BIDIR_OE_BIT];
  wire [15:0] write_val = {bidir_oe_new, merged[AUX_OE_BIT], 6'h00,
    new_divs};
  wire [15:0] nxt_freq_ctrl = wr_take ? write_val : cur_reg;

  // strap synchroniser, two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta_ff <= 3'h0;
      strap_sync_ff <= 3'h0;
      bidir_meta_ff <= 1'b0;
      bidir_sync_ff <= 1'b0;
    end else begin
      strap_meta_ff <= mode_strap_pins;
      strap_sync_ff <= strap_meta_ff;
      bidir_meta_ff <= bidir_clk_i;
      bidir_sync_ff <= bidir_meta_ff;
    end
  end

  // strap capture after release; mode then held until next reset
  wire load_now = !loaded_ff && (load_cnt_ff == 2'(STRAP_SYNC_CYCLES));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_cnt_ff <= 2'h0;
      loaded_ff <= 1'b0;
      mode_ff <= 3'h0;
    end else begin
      if (!loaded_ff && !load_now) load_cnt_ff <= load_cnt_ff + 2'h1;
      if (load_now) begin
        mode_ff <= strap_sync_ff;
        loaded_ff <= 1'b1;
      end
    end
  end

  // register load from mode table, then software writes
  // reset value depends on mode
  wire [15:0] rst_for_strap = (strap_sync_ff == 3'h0) ? RST_MODE0 :
    (strap_sync_ff == 3'h1) ? RST_MODE1 :
    (strap_sync_ff == 3'h2) ? RST_MODE2 :
    (strap_sync_ff == 3'h3) ? RST_MODE3 :
    (strap_sync_ff == 3'h4) ? RST_MODE4 :
    (strap_sync_ff == 3'h5) ? RST_MODE5 :
    (strap_sync_ff == 3'h6) ? RST_MODE6 : RST_MODE7;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) freq_ctrl_reg_ff <= RST_MODE7;
    else if (load_now) freq_ctrl_reg_ff <= rst_for_strap;
    else freq_ctrl_reg_ff <= nxt_freq_ctrl;
  end

  // apb answer; reads return the halfword, upper bits zero
  // byte, halfword, word reads all return the register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= acc_phase;
      pslverr_ff <= acc_phase && bad_addr;
      prdata_ff <= (acc_phase && !pwrite && addr_hit) ? {16'h0, cur_reg} : 32'h0;
    end
  end

  // aux divider: toggling counter gives x1 (pclk/2 reference), half, quarter
  wire [1:0] aux_div = cur_reg[AUX_DIV_LSB +: 2];
  wire [1:0] aux_lim = (aux_div == DIV_X1) ? 2'h0 :
    (aux_div == DIV_HALF) ? 2'h1 : 2'h3;
  wire aux_wrap = (aux_cnt_ff >= aux_lim);
  // bidir pin copies the aux clock at extbus x1, toggles every cycle at other divider codes
  wire [1:0] ext_div = cur_reg[EXTBUS_DIV_LSB +: 2];

  // pin drivers and decoded outputs; all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_cnt_ff <= 2'h0;
      aux_clk_ff <= 1'b0;
      aux_oe_ff <= 1'b0;
      bidir_o_ff <= 1'b0;
      bidir_oe_ff <= 1'b0;
      src_ff <= SRC_OSC;
      pll1_ff <= PLL_OFF;
      pll2_ff <= PLL_OFF;
      phase_ff <= PH_NONE;
    end else begin
      // aux clock at register ratio, free running
      aux_cnt_ff <= aux_wrap ? 2'h0 : aux_cnt_ff + 2'h1;
      if (aux_wrap) aux_clk_ff <= ~aux_clk_ff;
      aux_oe_ff <= loaded_ff && cur_reg[AUX_OE_BIT];
      bidir_oe_ff <= loaded_ff && cur_reg[BIDIR_OE_BIT];
      bidir_o_ff <= (ext_div == DIV_X1) ? aux_clk_ff : ~bidir_o_ff;
      src_ff <= dec_src;
      pll1_ff <= dec_pll1;
      pll2_ff <= dec_pll2;
      phase_ff <= dec_phase;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign aux_clk_o = aux_clk_ff;
  assign aux_clk_oe = aux_oe_ff;
  assign bidir_clk_o = bidir_o_ff;
  assign bidir_clk_oe = bidir_oe_ff;
  assign mode_o = mode_ff;
  assign src_sel_o = src_ff;
  assign pll1_factor_o = pll1_ff;
  assign pll2_factor_o = pll2_ff;
  assign phase_rel_o = phase_ff;
  assign core_div_o = freq_ctrl_reg_ff[CORE_DIV_LSB +: 2];
  assign periph_div_o = freq_ctrl_reg_ff[PERIPH_DIV_LSB +: 2];
  assign extbus_div_o = freq_ctrl_reg_ff[EXTBUS_DIV_LSB +: 2];

  // assertions; decode checks wait for the strap load, since the outputs
  // still carry reset values on the first edges after a reset release
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  bidir_oe_lock_a: assert property (
    loaded_ff && mode_ff <= 3'h3 |-> cur_reg[BIDIR_OE_BIT])
    else $error("bidir enable cleared in mode 0-3");
  bidir_oe_off_a: assert property (
    loaded_ff && mode_ff >= 3'h6 |-> !cur_reg[BIDIR_OE_BIT])
    else $error("bidir enable set in mode 6-7");
  bidir_oe_follow_a: assert property (
    loaded_ff |=> bidir_clk_oe == $past(cur_reg[BIDIR_OE_BIT]))
    else $error("bidir enable does not follow register");
  no_bad_div_a: assert property (
    loaded_ff |-> cur_reg[EXTBUS_DIV_LSB +: 2] != DIV_BAD
    && cur_reg[PERIPH_DIV_LSB +: 2] != DIV_BAD && cur_reg[CORE_DIV_LSB +: 2] != DIV_BAD
    && cur_reg[AUX_DIV_LSB +: 2] != DIV_BAD)
    else $error("forbidden divider code stored");
  reserved_zero_a: assert property (
    (cur_reg & ~FREQ_CTRL_WMASK) == 16'h0000)
    else $error("reserved register bits not zero");
  early_write_a: assert property (
    !loaded_ff && !load_now |=> cur_reg == RST_MODE7)
    else $error("register changed before strap load");
  reset_load_a: assert property (
    $rose(loaded_ff) |-> cur_reg == dec_reset)
    else $error("register not loaded with mode reset value");

  aux_oe_follow_a: assert property (
    loaded_ff |=> aux_clk_oe == $past(cur_reg[AUX_OE_BIT]))
    else $error("aux enable does not follow register");
  aux_toggle_a: assert property (
    loaded_ff && aux_wrap |=> aux_clk_o != $past(aux_clk_o))
    else $error("aux clock missed a toggle");
  aux_hold_a: assert property (
    loaded_ff && !aux_wrap |=> $stable(aux_clk_o))
    else $error("aux clock toggled early");

  mode_capture_a: assert property (
    load_now |=> mode_o == $past(strap_sync_ff))
    else $error("mode not taken from straps");
  mode_hold_a: assert property (
    loaded_ff |=> $stable(mode_o))
    else $error("mode changed without reset");
  pll_mode01_a: assert property (
    loaded_ff && mode_ff[2:1] == 2'h0 |=> pll1_factor_o == PLL_X2
    && pll2_factor_o == PLL_X2)
    else $error("mode 0/1 pll setup wrong");
  pll_mode23_a: assert property (
    loaded_ff && mode_ff[2:1] == 2'h1 |=> pll1_factor_o == PLL_X1
    && pll2_factor_o == PLL_X4)
    else $error("mode 2/3 pll setup wrong");
  pll_mode45_a: assert property (
    loaded_ff && mode_ff[2:1] == 2'h2 |=> pll1_factor_o == PLL_OFF
    && pll2_factor_o == PLL_X4)
    else $error("mode 4/5 pll setup wrong");
  pll_mode6_a: assert property (
    loaded_ff && mode_ff == 3'h6 |=> pll1_factor_o == PLL_X2
    && pll2_factor_o == PLL_OFF && src_sel_o == SRC_BIDIR)
    else $error("mode 6 setup wrong");
  pll_mode7_a: assert property (
    loaded_ff && mode_ff == 3'h7 |=> pll1_factor_o == PLL_X1
    && pll2_factor_o == PLL_OFF && src_sel_o == SRC_BIDIR)
    else $error("mode 7 setup wrong");
  src_osc_a: assert property (
    loaded_ff && mode_ff <= 3'h5 |=> src_sel_o == SRC_OSC)
    else $error("oscillator source not selected");
  phase_none_a: assert property (
    loaded_ff && mode_ff[2:1] == 2'h2 |=> phase_rel_o == PH_NONE)
    else $error("phase relation set in mode 4/5");

  apb_wait_a: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
  apb_pulse_a: assert property (
    pready |=> !pready)
    else $error("apb answer held too long");
  err_with_ready_a: assert property (
    pslverr |-> pready)
    else $error("slave error outside an answer");
  bad_addr_drop_a: assert property (
    loaded_ff && psel && penable && pready && !addr_hit |=> $stable(cur_reg))
    else $error("unmapped access changed the register");

  // main scenarios reached
  write_cov: cover property (wr_take);
  read_cov: cover property (psel && penable && pready && !pwrite);
  aux_hiz_cov: cover property (loaded_ff && !aux_clk_oe);
  bidir_on_cov: cover property (mode_ff == 3'h4 && bidir_clk_oe);
  // the synchronised pin clock is only observed here, in the pin-source modes
  bidir_in_cov: cover property (mode_ff[2:1] == 2'h3 && $changed(bidir_sync_ff));
endmodule

// ===== clock_mode_pll_select_tb.sv
// self-checking bench for the clock mode selection block
module clock_mode_pll_select_tb
  import clk_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready, pslverr, aux_clk_o, aux_clk_oe, bidir_clk_i, bidir_clk_o, bidir_clk_oe;
  logic [2:0] mode_sel = '0;
  logic [2:0] straps, mode_o, pll1_factor_o, pll2_factor_o;
  logic [1:0] src_sel_o, phase_rel_o, core_div_o, periph_div_o, extbus_div_o;
  logic [31:0] r;
  logic e, b15, prev;
  logic [1:0] dd;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  logic [15:0] rst_tab [8] = '{RST_MODE0, RST_MODE1, RST_MODE2, RST_MODE3,
                               RST_MODE4, RST_MODE5, RST_MODE6, RST_MODE7};
  logic [2:0] p1_tab [8] = '{PLL_X2, PLL_X2, PLL_X1, PLL_X1, PLL_OFF, PLL_OFF, PLL_X2, PLL_X1};
  logic [2:0] p2_tab [8] = '{PLL_X2, PLL_X2, PLL_X4, PLL_X4, PLL_X4, PLL_X4, PLL_OFF, PLL_OFF};
  // phase code per mode and extbus divider code, from the resulting bus clock ratio
  logic [1:0] ph_tab [8][3] = '{'{2'h2, 2'h1, 2'h3}, '{2'h2, 2'h1, 2'h3},
    '{2'h1, 2'h3, 2'h3}, '{2'h1, 2'h3, 2'h3}, '{2'h0, 2'h0, 2'h0}, '{2'h0, 2'h0, 2'h0},
    '{2'h2, 2'h1, 2'h3}, '{2'h1, 2'h3, 2'h3}};

  // clock generator, 50 ns period
  always #25 pclk = ~pclk;

  clock_mode_pll_select i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_strap_pins(straps), .aux_clk_o(aux_clk_o),
    .aux_clk_oe(aux_clk_oe), .bidir_clk_i(bidir_clk_i), .bidir_clk_o(bidir_clk_o),
    .bidir_clk_oe(bidir_clk_oe), .mode_o(mode_o), .src_sel_o(src_sel_o),
    .pll1_factor_o(pll1_factor_o), .pll2_factor_o(pll2_factor_o),
    .phase_rel_o(phase_rel_o), .core_div_o(core_div_o), .periph_div_o(periph_div_o),
    .extbus_div_o(extbus_div_o));

  clk_board_model i_board (
    .pclk(pclk), .mode_sel(mode_sel), .bidir_clk_o(bidir_clk_o),
    .bidir_clk_oe(bidir_clk_oe), .mode_strap_pins(straps), .bidir_clk_i(bidir_clk_i));

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; one edge before setup, waits for pready under a bound, returns as psel drops with no idle cycle after
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? s : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk("pready timeout", 32'h1, 32'h0);
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // count level changes of one clock pin over 16 cycles
  task toggles(input logic sel_aux);
    n = 0;
    prev = sel_aux ? aux_clk_o : bidir_clk_o;
    repeat (16) begin
      @(posedge pclk);
      if ((sel_aux ? aux_clk_o : bidir_clk_o) !== prev) n++;
      prev = sel_aux ? aux_clk_o : bidir_clk_o;
    end
  endtask

  initial begin
    for (int m = 0; m < 8; m++) begin
      mode_sel <= 3'(m);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(1'b0, FREQ_CTRL_ADDR, 32'h0, 4'hf);
      chk("reset value", {16'h0, rst_tab[m]}, r);
      chk("mapped err", 32'h0, {31'h0, e});
      chk("mode", 32'(m), {29'h0, mode_o});
      chk("source", {30'h0, (m > 5) ? SRC_BIDIR : SRC_OSC}, {30'h0, src_sel_o});
      chk("pll1", {29'h0, p1_tab[m]}, {29'h0, pll1_factor_o});
      chk("pll2", {29'h0, p2_tab[m]}, {29'h0, pll2_factor_o});
      chk("bidir oe reset", {31'h0, m < 4}, {31'h0, bidir_clk_oe});
      chk("aux oe reset", 32'h1, {31'h0, aux_clk_oe});
      b15 = rst_tab[m][15];
      for (int d = 0; d < 3; d++) begin
        dd = 2'(d);
        apb(1'b1, FREQ_CTRL_ADDR, {16'h0, b15, 1'b1, 6'h3f, {4{dd}}}, 4'h3);
        apb(1'b0, FREQ_CTRL_ADDR, 32'h0, 4'hf);
        chk("fields", {16'h0, b15, 1'b1, 6'h0, {4{dd}}}, r);
        chk("dividers", {26'h0, {3{dd}}}, {26'h0, core_div_o, periph_div_o, extbus_div_o});
        chk("phase", {30'h0, ph_tab[m][d]}, {30'h0, phase_rel_o});
        toggles(1'b1);
        chk("aux toggles", 32'(16 >> d), 32'(n));
      end
      // forbidden code in every field through the low lane only
      apb(1'b1, FREQ_CTRL_ADDR, 32'h0000_00ff, 4'h1);
      apb(1'b0, FREQ_CTRL_ADDR, 32'h0, 4'hf);
      chk("code 11 kept", {16'h0, b15, 1'b1, 6'h0, 8'haa}, r);
      apb(1'b1, FREQ_CTRL_ADDR, {16'h0, m > 3, 15'h0}, 4'h3);
      apb(1'b0, FREQ_CTRL_ADDR, 32'h0, 4'hf);
      chk("bidir oe write", {16'h0, m < 6, 15'h0}, r);
      chk("bidir oe pin", {31'h0, m < 6}, {31'h0, bidir_clk_oe});
      chk("aux oe off", 32'h0, {31'h0, aux_clk_oe});
      if (m == 4 || m == 5) begin
        toggles(1'b0);
        chk("bidir drives", 32'h1, {31'h0, n > 0});
      end
    end
    // unmapped word next to the register
    apb(1'b0, FREQ_CTRL_ADDR + 32'h4, 32'h0, 4'hf);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    report_and_stop();
  end
endmodule
